// [dv/crc32_accumulator_test.sv]
// Self-checking bench for the CRC-32 accumulator register port.
// Assumes crcacc_top, crcacc_pkg and crcacc_defines.svh are compiled.
`timescale 1ns/1ps
`include "crcacc_defines.svh"

module crc32_accumulator_test
  import crcacc_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  crcacc_req_t req = '0;
  logic        ready;
  logic        busy;
  crcacc_rsp_t rsp;
  int          failures = 0;
  int          n_checks = 0;
  logic [31:0] rd;
  logic [31:0] model = 32'hFFFFFFFF;

  // ============================================================
  // Clock, design and reference
  always #12.5 sys_clk = ~sys_clk;

  crcacc_top dut_u (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .reg_req   (req),
    .reg_ready (ready),
    .reg_rsp   (rsp),
    .calc_busy (busy)
  );

  // MSB-first shift fold, no reflection, no final inversion
  function automatic logic [31:0] crc_word(input logic [31:0] c,
                                           input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      c = {c[30:0], 1'b0} ^ ((c[31] ^ w[i]) ? `CRCACC_POLY : 32'h00000000);
    end
    return c;
  endfunction

  // ============================================================
  // Shared port tasks; each is entered 1 ns after a rising edge
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: read %h, wanted %h", $time, got, exp);
    end
  endtask

  // Holds the request until ready is seen, leaves sel high
  task automatic access(input logic wr, input logic [7:0] a,
                        input logic [31:0] d);
    int n;
    n = 0;
    req = '{sel: 1'b1, write: wr, addr: a, wdata: d};
    while (ready !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n == 50) begin
      failures++;
      $display("unexpected at %0t: port stalled too long", $time);
      tally_and_finish();
    end
    @(posedge sys_clk);
    #1;
    rd = rsp.rdata;
    if (!wr) begin
      n_checks++;
      if (rsp.rvalid !== 1'b1) begin
        failures++;
        $display("unexpected at %0t: read answer missing", $time);
      end
    end
  endtask

  task automatic idle;
    req.sel = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic read_check(input logic [7:0] a, input logic [31:0] exp);
    access(1'b0, a, 32'h00000000);
    idle();
    check(rd, exp);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 50) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n == 50) begin
      failures++;
      $display("unexpected at %0t: engine never idle", $time);
      tally_and_finish();
    end
  endtask

  // ============================================================
  // Scenarios
  task automatic t_reset_values;
    read_check(8'h00, 32'hFFFFFFFF);
    read_check(8'h04, 32'h00000000);
    read_check(8'h08, 32'h00000000);
    read_check(8'h0C, 32'h00000000);
  endtask

  // Three words back to back: one folds, one buffers, one stalls
  task automatic t_accumulate;
    access(1'b1, 8'h00, 32'h12345678);
    access(1'b1, 8'h00, 32'h00000000);
    access(1'b1, 8'h00, 32'hDEADBEEF);
    idle();
    model = crc_word(crc_word(crc_word(model, 32'h12345678),
                              32'h00000000), 32'hDEADBEEF);
    wait_idle();
    read_check(8'h00, model);
  endtask

  // Reads taken four and five edges after the word: old, then new value
  task automatic t_latency;
    access(1'b1, 8'h00, 32'h80000001);
    idle();
    repeat (2) @(posedge sys_clk);
    #1;
    access(1'b0, 8'h00, 32'h00000000);
    check(rd, model);
    model = crc_word(model, 32'h80000001);
    read_check(8'h00, model);
  endtask

  // Reinitialise while busy; scratch byte must survive it
  task automatic t_scratch_reinit;
    access(1'b1, 8'h04, 32'hFFFFFFA5);
    access(1'b1, 8'h00, 32'hCAFEF00D);
    access(1'b1, 8'h08, 32'h00000001);
    idle();
    read_check(8'h08, 32'h00000000);
    read_check(8'h00, 32'hFFFFFFFF);
    read_check(8'h04, 32'h000000A5);
    access(1'b1, 8'h00, 32'h0000FFFF);
    idle();
    wait_idle();
    read_check(8'h00, crc_word(32'hFFFFFFFF, 32'h0000FFFF));
  endtask

  // ============================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    t_reset_values();
    t_accumulate();
    t_latency();
    t_scratch_reinit();
    tally_and_finish();
  end
endmodule

// [dv/crcacc_assertions.sv]
// Concurrent checks on the CRC-32 accumulator register port and engine.
// Assumes the port types of crcacc_pkg; bound to crcacc_top below.
`timescale 1ns/1ps

module crcacc_assertions
  import crcacc_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire crcacc_req_t reg_req,
  input wire logic        reg_ready,
  input wire crcacc_rsp_t reg_rsp,
  input wire logic        calc_busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // ============================================================
  // Accesses taken at the port
  wire logic taken    = reg_req.sel && reg_ready;
  wire logic taken_rd = taken && !reg_req.write;
  wire logic taken_wd = taken && reg_req.write && reg_req.addr == 8'h00;
  wire logic taken_ri = taken && reg_req.write && reg_req.addr == 8'h08
                        && reg_req.wdata[0];

  // ============================================================
  // Read answers, engine timing and reinitialise handshake
  AST_RVALID_AFTER_READ: assert property (taken_rd |=> reg_rsp.rvalid)
    else $error("read answer missing");
  AST_NO_STRAY_RVALID: assert property (!taken_rd |=> !reg_rsp.rvalid)
    else $error("read answer without a read");
  AST_RDATA_HOLDS: assert property (!reg_rsp.rvalid
    |-> $stable(reg_rsp.rdata))
    else $error("read data moved without a read");
  AST_BUSY_FOUR: assert property (taken_wd && !calc_busy
    |=> calc_busy[*4])
    else $error("engine not busy for four cycles");
  AST_BUFFER_TAKES: assert property (taken_wd && !calc_busy
    |=> reg_ready)
    else $error("second word not accepted");
  AST_SCRATCH_UPPER: assert property (taken_rd && reg_req.addr == 8'h04
    |=> reg_rsp.rdata[31:8] == 24'h000000)
    else $error("scratch upper bits not zero");
  AST_CONTROL_UPPER: assert property (taken_rd && reg_req.addr == 8'h08
    |=> reg_rsp.rdata[31:1] == 31'h00000000)
    else $error("control upper bits not zero");
  AST_UNMAPPED_ZERO: assert property (taken_rd && reg_req.addr == 8'h0C
    |=> reg_rsp.rdata == 32'h00000000)
    else $error("unmapped read not zero");
  AST_REINIT_STALL: assert property (taken_ri
    |=> !reg_ready ##[1:20] reg_ready)
    else $error("reinitialise did not stall and finish");
endmodule

bind crcacc_top crcacc_assertions chk_u (
  .sys_clk   (sys_clk),
  .rst       (rst),
  .reg_req   (reg_req),
  .reg_ready (reg_ready),
  .reg_rsp   (reg_rsp),
  .calc_busy (calc_busy)
);

// [src/crcacc_defines.svh]
// Constants of the CRC-32 accumulator: offsets, fields, resets, timing.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef CRCACC_DEFINES_SVH
`define CRCACC_DEFINES_SVH

// ============================================================
// Register offsets (byte addresses)
`define CRCACC_OFS_CHECKSUM  8'h00
`define CRCACC_OFS_SCRATCH   8'h04
`define CRCACC_OFS_CONTROL   8'h08

// ============================================================
// Reset values and fields
`define CRCACC_CHECKSUM_RESET 32'hFFFFFFFF
`define CRCACC_SCRATCH_RESET  8'h00
`define CRCACC_SCRATCH_MSB    7
`define CRCACC_REINIT_BIT     0

// ============================================================
// Generator polynomial, MSB first, implicit x^32 term
`define CRCACC_POLY          32'h04C11DB7

// ============================================================
// Timing: cycles from word entry to readable result
`define CRCACC_CALC_CYCLES   4
`define CRCACC_LAST_STEP     2'h3

`endif

// [src/crcacc_fold.sv]
// Byte fold of the CRC-32 engine: running value plus one data byte.
// Assumes the caller registers the result; purely combinational.
`timescale 1ns/1ps
`include "crcacc_defines.svh"

module crcacc_fold
  import crcacc_pkg::*;
(
  input  wire logic [31:0] crc_in,
  input  wire logic [7:0]  data_in,
  output logic      [31:0] crc_out
);

  // ============================================================
  // One bit step, most significant bit first, no reflection
  function automatic logic [31:0] crcacc_bit_step(
    input logic [31:0] c,
    input logic        d
  );
    logic fb;
    fb = c[31] ^ d;
    crcacc_bit_step = {c[30:0], 1'b0} ^ (fb ? `CRCACC_POLY : 32'h00000000);
  endfunction

  // Eight bit steps from bit 7 down to bit 0
  always_comb begin
    logic [31:0] c;
    c = crc_in;
    for (int i = 7; i >= 0; i--) begin
      c = crcacc_bit_step(c, data_in[i]);
    end
    crc_out = c;
  end

endmodule

// [src/crcacc_pkg.sv]
// Types shared by the CRC-32 accumulator design files.
// Assumes nothing of its surroundings.
package crcacc_pkg;

  // ============================================================
  // Register port request, one word per access
  typedef struct packed {
    logic        sel;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } crcacc_req_t;

  // Register port answer, valid one cycle after a taken read
  typedef struct packed {
    logic        rvalid;
    logic [31:0] rdata;
  } crcacc_rsp_t;

  // Engine states, Gray coded along idle -> fold -> idle
  typedef enum logic [0:0] {
    CRCACC_IDLE = 1'b0,
    CRCACC_FOLD = 1'b1
  } crcacc_state_t;

endpackage

// [src/crcacc_top.sv]
// CRC-32 accumulator: data, scratch and control registers plus engine.
// Assumes a simple word register port synchronous to sys_clk; accesses
// are taken when sel and ready are both high.
`timescale 1ns/1ps
`include "crcacc_defines.svh"

// Operation
// - Updated checksum readable four cycles after entry
// - Fixed generator polynomial 0x4C11DB7, not programmable
// - Checksum register write is data, holds result
// - Each word folds into the held checksum
// - One-word input buffer; writes stall while it is full until the last byte
// - Checksum read returns last result, not word
// - Scratch byte reads back, unrelated to calculation
// - Scratch in bits 7:0, upper bits zero
// - Reinitialise bit loads checksum with all ones
// - Reinitialise bit clears itself after action
// - Reinitialise leaves the scratch byte unchanged
module crcacc_top
  import crcacc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire crcacc_req_t reg_req,
  output logic             reg_ready,
  output crcacc_rsp_t      reg_rsp,
  output logic             calc_busy
);

  // ============================================================
  // Storage
  logic [31:0]   checksum_value;
  logic [7:0]    scratch_byte_field;
  logic          reinit_pending;
  logic [31:0]   work_crc;
  logic [31:0]   work_word;
  logic [1:0]    step;
  logic          buf_valid;
  logic [31:0]   buf_word;
  crcacc_state_t state;
  crcacc_state_t next_state;
  logic [31:0]   rdata_q;
  logic          rvalid_q;

  // ============================================================
  // Address decode and access qualification
  wire hit_checksum = reg_req.addr == `CRCACC_OFS_CHECKSUM;
  wire hit_scratch  = reg_req.addr == `CRCACC_OFS_SCRATCH;
  wire hit_control  = reg_req.addr == `CRCACC_OFS_CONTROL;
  wire take         = reg_req.sel && reg_ready;
  wire take_write   = take && reg_req.write;
  wire take_read    = take && !reg_req.write;
  wire wr_checksum  = take_write && hit_checksum;
  wire wr_scratch   = take_write && hit_scratch;
  wire wr_control   = take_write && hit_control;
  wire reinit_req   = wr_control && reg_req.wdata[`CRCACC_REINIT_BIT];

  // Engine is free when idle, or finishing its last byte this cycle
  wire fold_last    = (state == CRCACC_FOLD) && (step == `CRCACC_LAST_STEP);
  wire engine_free  = (state == CRCACC_IDLE) || fold_last;

  // Word to start next: buffered word first, else a word written now
  wire start_buf    = engine_free && buf_valid && !reinit_pending;
  wire start_direct = engine_free && !buf_valid && wr_checksum;
  wire start_word   = start_buf || start_direct;
  wire [31:0] start_data = start_buf ? buf_word : reg_req.wdata;

  // A written word waits in the buffer when the engine cannot take it
  wire to_buffer    = wr_checksum && !start_direct;

  // Reinitialise only once engine and buffer have drained
  wire reinit_fire  = reinit_pending && (state == CRCACC_IDLE) && !buf_valid;

  // ============================================================
  // Ready: only a full buffer or a waiting reinitialise holds writes off
  assign reg_ready = !(buf_valid && !engine_free) && !reinit_pending;
  assign calc_busy = (state == CRCACC_FOLD) || buf_valid;

  // ============================================================
  // Byte fold of the running value, top byte of the word first
  wire [31:0] fold_out;
  wire [31:0] fold_base = (state == CRCACC_FOLD) ? work_crc : checksum_value;

  crcacc_fold u_fold (
    .crc_in  (work_crc),
    .data_in (work_word[31:24]),
    .crc_out (fold_out)
  );

  // ============================================================
  // Engine state sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      CRCACC_IDLE: begin
        if (start_word) begin
          next_state = CRCACC_FOLD;
        end
      end
      CRCACC_FOLD: begin
        if (fold_last && !start_word) begin
          next_state = CRCACC_IDLE;
        end
      end
    endcase
  end

  // Seed for a new word: the result now being finished, or the held one
  wire [31:0] seed = fold_last ? fold_out : fold_base;

  // ============================================================
  // Engine registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state     <= CRCACC_IDLE;
      step      <= 2'h0;
      work_crc  <= `CRCACC_CHECKSUM_RESET;
      work_word <= 32'h00000000;
    end else begin
      state <= next_state;
      if (start_word) begin
        step      <= 2'h0;
        work_crc  <= seed;
        work_word <= start_data;
      end else if (state == CRCACC_FOLD) begin
        step      <= step + 2'h1;
        work_crc  <= fold_out;
        work_word <= {work_word[23:0], 8'h00};
      end
    end
  end

  // ============================================================
  // One-word input buffer
  // It fills only while the engine is busy; writes stall when it is
  // full and the engine is not on its last byte, or while a reinitialise is pending.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      buf_valid <= 1'b0;
      buf_word  <= 32'h00000000;
    end else begin
      if (to_buffer) begin
        buf_valid <= 1'b1;
        buf_word  <= reg_req.wdata;
      end else if (start_buf) begin
        buf_valid <= 1'b0;
      end
    end
  end

  // ============================================================
  // Checksum register: result after the fourth byte, or all ones
  // Reads during a calculation keep returning the previous result.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      checksum_value <= `CRCACC_CHECKSUM_RESET;
    end else begin
      if (reinit_fire) begin
        checksum_value <= `CRCACC_CHECKSUM_RESET;
      end else if (fold_last) begin
        checksum_value <= fold_out;
      end
    end
  end

  // ============================================================
  // Reinitialise bit: set by software, cleared by hardware when done
  // Ready is low while the bit is pending, so a second set cannot meet
  // the clear in one cycle and no data word can slip past it.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reinit_pending <= 1'b0;
    end else begin
      if (reinit_req) begin
        reinit_pending <= 1'b1;
      end else if (reinit_fire) begin
        reinit_pending <= 1'b0;
      end
    end
  end

  // ============================================================
  // Scratch byte: only its own write changes it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scratch_byte_field <= `CRCACC_SCRATCH_RESET;
    end else begin
      if (wr_scratch) begin
        scratch_byte_field <= reg_req.wdata[`CRCACC_SCRATCH_MSB:0];
      end
    end
  end

  // ============================================================
  // Read data selection; unmapped addresses read as zero
  wire [31:0] rd_checksum = checksum_value;
  wire [31:0] rd_scratch  = {24'h000000, scratch_byte_field};
  wire [31:0] rd_control  = {31'h00000000, reinit_pending};
  wire [31:0] rd_mux =
    hit_checksum ? rd_checksum :
    hit_scratch  ? rd_scratch  :
    hit_control  ? rd_control  : 32'h00000000;

  // Registered read answer, one cycle after the read is taken
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_q  <= 32'h00000000;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= take_read;
      if (take_read) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // Answer leaves as one struct; both fields come from flip-flops
  assign reg_rsp = '{rvalid: rvalid_q, rdata: rdata_q};

endmodule
